/* cpu_proc_model.sv */
// Purpose: CPU side running the procedure program from RAM
// Assumes: Same clock as the block
// Notes: Faults appear only when the bench commands one
`timescale 1ns/100ps
`default_nettype none
module cpu_proc_model
(
  input wire logic busy_i,
  input wire logic [2:0] fault_sel_i,
  output logic exec_from_ram_o,
  output logic emulator_enable_o,
  output logic irq_o,
  output logic array_read_o,
  output logic sleep_o,
  output logic other_master_o
);
  assign exec_from_ram_o = 1'b1;
  assign emulator_enable_o = 1'b0;
  assign array_read_o = busy_i && (fault_sel_i == 3'h2);
  // Faults only during an operation, as commanded
  assign irq_o = busy_i && (fault_sel_i == 3'h1);
  assign sleep_o = busy_i && (fault_sel_i == 3'h3);
  assign other_master_o = busy_i && (fault_sel_i == 3'h4);
endmodule // cpu_proc_model
`default_nettype wire

/* flash_block_map.sv */
// Purpose: Maps an erase block number to its base address and size class
// Assumes: Eight 4K, one 32K and seven 64K blocks from address zero
// Notes: Pure combinational
`timescale 1ns/100ps
`default_nettype none
`include "flash_pe_defs.svh"
module flash_block_map
#(
  parameter int NUM_BLOCKS = `ERASE_BLOCKS
)
(
  input wire logic [7:0] block_i,
  output logic [23:0] base_o,
  output logic small_o,
  output logic valid_o
);
  always_comb
  begin
    base_o = 24'h00_0000;
    small_o = 1'b0;
    valid_o = (block_i < 8'(NUM_BLOCKS));
    if (block_i < 8'd8)
    begin
      base_o = {12'h000, block_i[3:0], 8'h00} << 4;
      small_o = 1'b1;
    end
    else if (block_i == 8'd8)
    begin
      base_o = 24'h00_8000;
    end
    else if (valid_o)
    begin
      base_o = {4'h0, block_i[3:0] - 4'd8, 16'h0000};
    end
  end
endmodule // flash_block_map
`default_nettype wire

/* flash_pe_defs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the flash program/erase interface
// Assumes: AXI4-Lite byte addresses, one register per aligned word
// Notes: Included by its bare name
`ifndef FLASH_PE_DEFS_SVH
`define FLASH_PE_DEFS_SVH

`define OFS_CODE_CTRL_STATUS 8'h00
`define OFS_PROG_ROUTINE_SEL 8'h04
`define OFS_ERASE_ROUTINE_SEL 8'h08
`define OFS_PROTECTION_KEY 8'h0C
`define OFS_ARRAY_SELECT 8'h10
`define OFS_COPY_DEST 8'h14
`define OFS_RAM_OVERLAY 8'h18
`define OFS_OP_CONTROL 8'h1C
`define OFS_DEST_ADDR 8'h20
`define OFS_ERASE_BLOCK 8'h24
`define OFS_RESULT 8'h28

`define CCS_RESET 8'h80
`define CCS_FLASH_ERR_BIT 4
`define CCS_COPY_REQ_BIT 0
`define DEST_ERR_BIT 7
`define KEY_COPY 8'hA5
`define KEY_PROG 8'h5A
`define KEY_RESET 8'h00
`define ARRAY_SEL_BOOT 8'hAA
`define DEST_MAX 7'h02
`define OVERLAY_SELECT_BIT 3

`define ERASE_BLOCKS 16
`define SMALL_BLOCKS 8
`define COPY_WORDS 16'h0400
`define OP_TIME_US 1
`define OP_CYCLES ((`OP_TIME_US * 1000) / 10)

`define RES_PASS 2'b00
`define RES_FAIL 2'b01
`define RES_ALIGN 2'b10
`define RES_PROTECT 2'b11

`endif

/* flash_pe_interface.sv */
// Purpose: Register file and sequencer of the flash program/erase interface
// Assumes: AXI4-Lite slave, 100 MHz clock, byte data in low lanes
// Notes: Copy and operation lengths are modelled counts
`timescale 1ns/100ps
`default_nettype none
`include "flash_pe_defs.svh"
module flash_pe_interface
  import flash_pe_pkg::*;
#(
  parameter logic [15:0] COPY_WORDS = `COPY_WORDS,
  parameter logic [15:0] OP_CYCLES = 16'(`OP_CYCLES)
)
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_from_ram_i,
  input wire logic irq_pending_i,
  input wire logic array_read_i,
  input wire logic sleep_i,
  input wire logic other_master_i,
  input wire logic emulator_enable_in_i,
  input wire logic [2:0] mode_select_inputs_i,
  input wire logic boot_variant_select_i,
  output logic usb_boot_o,
  output logic embedded_map_o,
  output logic irq_disable_o,
  output logic flash_busy_o,
  output logic [2:0] copy_dest_sel_o,
  output logic [23:0] op_address_o,
  output logic overlay_active_o
);
  logic rst_meta_q, rstn_q;
  always_ff @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_q <= 1'b0;
      rstn_q <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rstn_q <= rst_meta_q;
    end
  end

  // Pins from outside: three stages, change taken when last two agree
  logic [4:0] pin_s1_q, pin_s2_q, pin_s3_q, pin_q;
  always_ff @(posedge clk_i or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      pin_s1_q <= 5'h0;
      pin_s2_q <= 5'h0;
      pin_s3_q <= 5'h0;
      pin_q <= 5'h0;
    end
    else
    begin
      pin_s1_q <= {emulator_enable_in_i, mode_select_inputs_i, boot_variant_select_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      if (pin_s2_q == pin_s3_q)
        pin_q <= pin_s3_q;
    end
  end
  logic emul_s, boot_mode_s;
  assign emul_s = pin_q[4];
  assign boot_mode_s = (pin_q[3:1] == 3'b010);
  assign usb_boot_o = boot_mode_s & pin_q[0];

  seq_state_type state_q;
  op_kind_type op_q;
  logic [7:0] key_q, array_sel_q, dest_q, overlay_q, erase_blk_q, ctrl_q;
  logic [23:0] addr_q;
  logic prog_sel_q, erase_sel_q, flash_err_q, copy_ok_q;
  logic [1:0] op_res_q;
  logic [15:0] cnt_q;

  // write taken when both channels present, one cycle
  logic wr_go, rd_go;
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= `OFS_RESULT);
  endfunction

  logic [7:0] wd;
  logic wb;
  assign wd = s_axi_wdata[7:0];
  // only the low byte lane strobe writes; the address register also takes lanes 1 and 2
  assign wb = wr_go & s_axi_wstrb[0] & mapped(s_axi_awaddr);
  function automatic logic hit(input logic [7:0] ofs, input logic [7:0] a);
    hit = (a == ofs);
  endfunction

  logic busy;
  assign busy = (state_q == ST_PROG) || (state_q == ST_ERASE) || (state_q == ST_COPY);

  always_ff @(posedge clk_i or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      key_q <= `KEY_RESET;
      array_sel_q <= 8'h00;
      overlay_q <= 8'h00;
      erase_blk_q <= 8'h00;
      addr_q <= 24'h00_0000;
      ctrl_q <= 8'h00;
      prog_sel_q <= 1'b0;
      erase_sel_q <= 1'b0;
    end
    else
    begin
      ctrl_q <= 8'h00;
      if (wb && hit(`OFS_PROTECTION_KEY, s_axi_awaddr))
        key_q <= wd;
      if (wb && hit(`OFS_ARRAY_SELECT, s_axi_awaddr) && !busy)
        array_sel_q <= wd;
      if (wb && hit(`OFS_RAM_OVERLAY, s_axi_awaddr))
        overlay_q <= wd;
      if (wb && hit(`OFS_ERASE_BLOCK, s_axi_awaddr) && !busy)
        erase_blk_q <= wd;
      if (wb && hit(`OFS_DEST_ADDR, s_axi_awaddr) && !busy)
        addr_q <= {s_axi_wdata[23:8], wd};
      if (wb && hit(`OFS_OP_CONTROL, s_axi_awaddr))
        ctrl_q <= wd;
      if (state_q == ST_COPY && cnt_q == 16'h0001)
      begin
        prog_sel_q <= 1'b0;
        erase_sel_q <= 1'b0;
      end
      else
      begin
        if (wb && hit(`OFS_PROG_ROUTINE_SEL, s_axi_awaddr))
          prog_sel_q <= wd[0];
        if (wb && hit(`OFS_ERASE_ROUTINE_SEL, s_axi_awaddr))
          erase_sel_q <= wd[0];
      end
    end
  end

  logic copy_req;
  assign copy_req = wb && hit(`OFS_CODE_CTRL_STATUS, s_axi_awaddr) && wd[`CCS_COPY_REQ_BIT]
                    && !overlay_q[`OVERLAY_SELECT_BIT] && key_q == `KEY_COPY && exec_from_ram_i
                    && state_q == ST_IDLE;
  logic dest_bad;
  assign dest_bad = dest_q[6:0] > `DEST_MAX;

  logic [23:0] blk_base;
  logic blk_small, blk_valid;
  flash_block_map #(.NUM_BLOCKS(`ERASE_BLOCKS)) u_map (
    .block_i(erase_blk_q),
    .base_o(blk_base),
    .small_o(blk_small),
    .valid_o(blk_valid)
  );

  // only the program key opens operations
  logic prot_ok;
  assign prot_ok = (key_q == `KEY_PROG) && !emul_s && !flash_err_q && copy_ok_q;

  // Fault causes, declared ahead of the sequencer that reads them
  logic fault;
  assign fault = irq_pending_i | array_read_i | sleep_i | other_master_i;

  always_ff @(posedge clk_i or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      state_q <= ST_IDLE;
      op_q <= OP_NONE;
      cnt_q <= 16'h0000;
      dest_q <= 8'h00;
      copy_ok_q <= 1'b0;
      op_res_q <= `RES_PASS;
    end
    else
    begin
      if (wb && hit(`OFS_COPY_DEST, s_axi_awaddr) && state_q == ST_IDLE)
        dest_q <= wd;
      case (state_q)
        ST_IDLE:
        begin
          if (copy_req)
          begin
            if (dest_bad)
              dest_q[`DEST_ERR_BIT] <= 1'b1;
            else
            begin
              state_q <= ST_COPY;
              cnt_q <= COPY_WORDS;
              copy_ok_q <= 1'b0;
            end
          end
          else if (ctrl_q[0] || ctrl_q[1])
          begin
            if (!prot_ok)
              op_res_q <= `RES_PROTECT;
            else if (ctrl_q[0] && addr_q[6:0] != 7'h00)
              op_res_q <= `RES_ALIGN;
            else if (ctrl_q[1] && !blk_valid)
              op_res_q <= `RES_FAIL;
            else
            begin
              state_q <= ctrl_q[0] ? ST_PROG : ST_ERASE;
              op_q <= ctrl_q[0] ? OP_PROGRAM : OP_ERASE;
              cnt_q <= OP_CYCLES;
            end
          end
        end
        ST_COPY:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001)
          begin
            copy_ok_q <= prog_sel_q ^ erase_sel_q;
            state_q <= ST_IDLE;
          end
        end
        ST_PROG, ST_ERASE:
        begin
          cnt_q <= cnt_q - 16'h0001;
          if (fault)
          begin
            op_res_q <= `RES_FAIL;
            state_q <= ST_DONE;
          end
          else if (cnt_q == 16'h0001)
          begin
            op_res_q <= `RES_PASS;
            state_q <= ST_DONE;
          end
        end
        ST_DONE:
        begin
          state_q <= ST_IDLE;
          op_q <= OP_NONE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rstn_q)
  begin
    if (!rstn_q)
      flash_err_q <= 1'b0;
    else if ((state_q == ST_PROG || state_q == ST_ERASE) && fault)
      flash_err_q <= 1'b1;
  end

  assign embedded_map_o = (state_q == ST_COPY);
  assign irq_disable_o = busy;
  assign flash_busy_o = (state_q == ST_PROG) || (state_q == ST_ERASE);
  assign copy_dest_sel_o = dest_q[2:0];
  // program unit base on 128 bytes
  assign op_address_o = (op_q == OP_ERASE) ? blk_base : {addr_q[23:7], 7'h00};
  assign overlay_active_o = overlay_q[`OVERLAY_SELECT_BIT] && erase_blk_q < 8'(`SMALL_BLOCKS) && blk_small;

  // fixed reserved bits, copy bit reads zero
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    case (a)
      `OFS_CODE_CTRL_STATUS: rd_mux = `CCS_RESET | {3'b000, flash_err_q, 4'h0};
      `OFS_PROG_ROUTINE_SEL: rd_mux = {7'h00, prog_sel_q};
      `OFS_ERASE_ROUTINE_SEL: rd_mux = {7'h00, erase_sel_q};
      `OFS_PROTECTION_KEY: rd_mux = key_q;
      `OFS_ARRAY_SELECT: rd_mux = array_sel_q;
      `OFS_COPY_DEST: rd_mux = dest_q;
      `OFS_RAM_OVERLAY: rd_mux = overlay_q;
      `OFS_DEST_ADDR: rd_mux = addr_q[7:0];
      `OFS_ERASE_BLOCK: rd_mux = erase_blk_q;
      `OFS_RESULT: rd_mux = {4'h0, busy, copy_ok_q, op_res_q};
      default: rd_mux = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge rstn_q)
  begin
    if (!rstn_q)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      if (wr_go)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(s_axi_awaddr) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (rd_go)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= mapped(s_axi_araddr) ? 2'b00 : 2'b10;
        s_axi_rdata <= {24'h00_0000, rd_mux(s_axi_araddr)};
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  a_err_sticky: assert property (@(posedge clk_i) disable iff (!rstn_q) $rose(flash_err_q) |=> flash_err_q[*8]) else $error("flash error flag fell");
  a_err_cause: assert property (@(posedge clk_i) disable iff (!rstn_q) $rose(flash_err_q) |-> $past(flash_busy_o)) else $error("flash error without operation");
  a_copy_done: assert property (@(posedge clk_i) disable iff (!rstn_q) $rose(embedded_map_o) |-> ##[1:1000] !embedded_map_o) else $error("copy never ends");
  a_irq_held: assert property (@(posedge clk_i) disable iff (!rstn_q) flash_busy_o |-> irq_disable_o) else $error("interrupts not held");
  a_dest_reject: assert property (@(posedge clk_i) disable iff (!rstn_q) copy_req && dest_bad |=> !embedded_map_o && dest_q[7]) else $error("bad destination copied");
  a_copy_key: assert property (@(posedge clk_i) disable iff (!rstn_q) $rose(embedded_map_o) |-> $past(key_q) == `KEY_COPY) else $error("copy without key");
  a_align_reject: assert property (@(posedge clk_i) disable iff (!rstn_q) state_q == ST_IDLE && ctrl_q[0] && addr_q[6:0] != 7'h00 |=> !flash_busy_o) else $error("misaligned program");
  a_prog_key: assert property (@(posedge clk_i) disable iff (!rstn_q) $rose(flash_busy_o) |-> $past(key_q) == `KEY_PROG) else $error("operation without key");
  a_boot_var: assert property (@(posedge clk_i) disable iff (!rstn_q) !boot_mode_s |-> !usb_boot_o) else $error("variant outside boot");
  a_resp_once: assert property (@(posedge clk_i) disable iff (!rstn_q) wr_go |=> s_axi_bvalid) else $error("no write response");
  c_copy: cover property (@(posedge clk_i) disable iff (!rstn_q) $fell(embedded_map_o));
  c_prog: cover property (@(posedge clk_i) disable iff (!rstn_q) op_q == OP_PROGRAM && state_q == ST_DONE);
  c_erase: cover property (@(posedge clk_i) disable iff (!rstn_q) op_q == OP_ERASE && state_q == ST_DONE);
endmodule // flash_pe_interface
`default_nettype wire

/* flash_pe_pkg.sv */
// Purpose: Types shared by the flash program/erase interface
// Assumes: Nothing
// Notes: Constants live in flash_pe_defs.svh
package flash_pe_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_COPY,
    ST_PROG,
    ST_ERASE,
    ST_DONE
  } seq_state_type;

  typedef enum logic [1:0] {
    OP_NONE,
    OP_PROGRAM,
    OP_ERASE
  } op_kind_type;
endpackage

/* test_flash_pe_interface.sv */
// Purpose: Self-checking bench for the flash program/erase interface
// Assumes: Copy and operation counts shortened to 4
// Notes: Erase always precedes programming of a region
`timescale 1ns/100ps
`default_nettype none
`include "flash_pe_defs.svh"
module test_flash_pe_interface;
  import flash_pe_pkg::*;
  logic clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic s_axi_rready = 1'b1;
  logic [2:0] mode_select_inputs_i = 3'h0;
  logic boot_variant_select_i = 1'b0;
  logic [2:0] fault_sel = 3'h0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire exec_from_ram_i, irq_pending_i, array_read_i, sleep_i, other_master_i, emulator_enable_in_i;
  wire usb_boot_o, embedded_map_o, irq_disable_o, flash_busy_o, overlay_active_o;
  wire [2:0] copy_dest_sel_o;
  wire [23:0] op_address_o;
  logic [23:0] op_seen = 24'h00_0000;
  logic saw_map = 1'b0;
  logic bad_irq = 1'b0;
  logic [31:0] d;
  logic [1:0] rsp;
  int err_count = 0;
  int comparisons = 0;

  flash_pe_interface #(.COPY_WORDS(16'h0004), .OP_CYCLES(16'h0004)) dut
  (
    .clk_i, .rstn_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .exec_from_ram_i, .irq_pending_i, .array_read_i, .sleep_i, .other_master_i, .emulator_enable_in_i,
    .mode_select_inputs_i, .boot_variant_select_i, .usb_boot_o, .embedded_map_o, .irq_disable_o,
    .flash_busy_o, .copy_dest_sel_o, .op_address_o, .overlay_active_o
  );

  cpu_proc_model cpu
  (
    .busy_i(flash_busy_o), .fault_sel_i(fault_sel), .exec_from_ram_o(exec_from_ram_i),
    .emulator_enable_o(emulator_enable_in_i), .irq_o(irq_pending_i), .array_read_o(array_read_i),
    .sleep_o(sleep_i), .other_master_o(other_master_i)
  );

  initial
  begin
    forever #5 clk_i = ~clk_i;
  end

  // Sticky observations; pulses are too short to poll over the bus
  always @(posedge clk_i)
  begin
    if (embedded_map_o)
      saw_map <= 1'b1;
    if (flash_busy_o)
      op_seen <= op_address_o;
    if (flash_busy_o && !irq_disable_o)
      bad_irq <= 1'b1;
  end

  task automatic finish_test;
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #300us;
    err_count++;
    finish_test;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset;
    rstn_i <= 1'b0;
    repeat (10) @(posedge clk_i);
    rstn_i <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask

  // Leading edge keeps a new request apart from the last release
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [3:0] s = 4'h1);
    @(posedge clk_i);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_wstrb <= s;
    {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
    do @(negedge clk_i); while (!(s_axi_awready && s_axi_wready));
    @(posedge clk_i);
    {s_axi_awvalid, s_axi_wvalid} <= 2'b00;
    do @(negedge clk_i); while (!s_axi_bvalid);
    rsp = s_axi_bresp;
    @(posedge clk_i);
  endtask

  task automatic wb(input logic [7:0] a, input logic [7:0] v);
    wr(a, {24'h00_0000, v});
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(negedge clk_i); while (!s_axi_arready);
    @(posedge clk_i);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk_i); while (!s_axi_rvalid);
    d = s_axi_rdata;
    rsp = s_axi_rresp;
    @(posedge clk_i);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a);
    chk(d & {24'h00_0000, m}, {24'h00_0000, e});
  endtask

  task automatic wait_done;
    int n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while ((embedded_map_o || flash_busy_o || n < 4) && n < 200);
    @(posedge clk_i);
  endtask

  // key then copy request; one routine selected
  task automatic copy(input logic p);
    wb(`OFS_PROG_ROUTINE_SEL, {7'h00, p});
    wb(`OFS_ERASE_ROUTINE_SEL, {7'h00, !p});
    wb(`OFS_COPY_DEST, 8'h02);
    wb(`OFS_PROTECTION_KEY, `KEY_COPY);
    wb(`OFS_CODE_CTRL_STATUS, 8'h01);
    wait_done;
  endtask

  // erase by block number, program only erased space
  task automatic op(input logic [1:0] k, input logic [23:0] v);
    wr((k == 2'h1) ? `OFS_DEST_ADDR : `OFS_ERASE_BLOCK, {8'h00, v});
    wb(`OFS_OP_CONTROL, {6'h00, k});
    wait_done;
  endtask

  function automatic logic [23:0] base_of(input logic [7:0] n);
    if (n < 8'h08)
      return {9'h000, n[2:0], 12'h000};
    if (n == 8'h08)
      return 24'h00_8000;
    return {4'h0, n[3:0] - 4'h8, 16'h0000};
  endfunction

  task automatic t_reset_values;
    rc(`OFS_CODE_CTRL_STATUS, 8'hFF, `CCS_RESET);
    rc(`OFS_PROTECTION_KEY, 8'hFF, `KEY_RESET);
    rc(`OFS_COPY_DEST, 8'hFF, 8'h00);
    wr(`OFS_PROTECTION_KEY, 32'h0000_5A00, 4'h2);
    rc(`OFS_PROTECTION_KEY, 8'hFF, 8'h00);
    rd(8'h3C);
    chk(32'(rsp), 32'h0000_0002);
    wb(8'h3C, 8'h11);
    chk(32'(rsp), 32'h0000_0002);
  endtask

  task automatic t_ctrl_bits;
    wb(`OFS_CODE_CTRL_STATUS, 8'hFF);
    rc(`OFS_CODE_CTRL_STATUS, 8'hFF, 8'h80);
    wb(`OFS_RAM_OVERLAY, 8'h08);
    chk(32'(overlay_active_o), 32'h0000_0001);
    wb(`OFS_PROTECTION_KEY, `KEY_COPY);
    wb(`OFS_CODE_CTRL_STATUS, 8'h01);
    repeat (8) @(posedge clk_i);
    chk(32'(saw_map), 32'h0000_0000);
    wb(`OFS_RAM_OVERLAY, 8'h00);
    chk(32'(overlay_active_o), 32'h0000_0000);
  endtask

  task automatic t_dest_error;
    wb(`OFS_PROG_ROUTINE_SEL, 8'h01);
    wb(`OFS_COPY_DEST, 8'h03);
    wb(`OFS_PROTECTION_KEY, `KEY_COPY);
    wb(`OFS_CODE_CTRL_STATUS, 8'h01);
    wait_done;
    rc(`OFS_COPY_DEST, 8'h80, 8'h80);
  endtask

  task automatic t_erase;
    logic [7:0] blk [5] = '{8'h00, 8'h07, 8'h08, 8'h09, 8'h0F};
    copy(1'b0);
    wb(`OFS_PROTECTION_KEY, `KEY_PROG);
    foreach (blk[i])
    begin
      op(2'h2, {16'h0000, blk[i]});
      chk(32'(op_seen), 32'(base_of(blk[i])));
      rc(`OFS_RESULT, 8'h03, `RES_PASS);
    end
  endtask

  task automatic t_copy;
    saw_map = 1'b0;
    copy(1'b1);
    chk(32'(saw_map), 32'h0000_0001);
    chk(32'(embedded_map_o), 32'h0000_0000);
    rc(`OFS_RESULT, 8'h04, 8'h04);
    rc(`OFS_CODE_CTRL_STATUS, 8'h01, 8'h00);
    chk(32'(copy_dest_sel_o), 32'h0000_0002);
  endtask

  task automatic t_program;
    wb(`OFS_PROTECTION_KEY, `KEY_PROG);
    op(2'h1, 24'h00_0040);
    rc(`OFS_RESULT, 8'h03, `RES_ALIGN);
    op(2'h1, 24'h00_0080);
    rc(`OFS_RESULT, 8'h03, `RES_PASS);
    chk(32'(op_seen), 32'h0000_0080);
    op(2'h1, 24'h00_0100);
    rc(`OFS_RESULT, 8'h03, `RES_PASS);
    chk(32'(op_seen), 32'h0000_0100);
    chk(32'(bad_irq), 32'h0000_0000);
  endtask

  task automatic t_protect;
    wb(`OFS_PROTECTION_KEY, 8'h33);
    op(2'h1, 24'h00_0180);
    rc(`OFS_RESULT, 8'h03, `RES_PROTECT);
  endtask

  task automatic boot_case(input logic [2:0] m, input logic v, input logic e);
    @(posedge clk_i);
    mode_select_inputs_i <= m;
    boot_variant_select_i <= v;
    repeat (8) @(posedge clk_i);
    chk(32'(usb_boot_o), 32'(e));
  endtask

  task automatic t_boot;
    boot_case(3'h2, 1'b1, 1'b1);
    boot_case(3'h2, 1'b0, 1'b0);
    boot_case(3'h0, 1'b1, 1'b0);
  endtask

  // Sticky error needs a fresh reset for each cause
  task automatic t_faults;
    for (int k = 1; k <= 4; k++)
    begin
      do_reset;
      copy(1'b0);
      wb(`OFS_PROTECTION_KEY, `KEY_PROG);
      @(posedge clk_i);
      fault_sel <= 3'(k);
      op(2'h2, 24'h00_0001);
      fault_sel <= 3'h0;
      rc(`OFS_CODE_CTRL_STATUS, 8'h10, 8'h10);
      op(2'h2, 24'h00_0002);
      rc(`OFS_RESULT, 8'h03, `RES_PROTECT);
    end
  endtask

  initial
  begin
    do_reset;
    t_reset_values;
    t_ctrl_bits;
    t_dest_error;
    t_erase;
    t_copy;
    t_program;
    t_protect;
    t_boot;
    t_faults;
    finish_test;
  end
endmodule // test_flash_pe_interface
`default_nettype wire
